// ---- common/rrbs_pkg.sv ----
// Constants and state layout of the reset and RAM back-up sequencer
// Contract
// - Reset floats every port pin and loads its output latch with 1.
// - Reset switches off all port pull-up transistors, shared pins included.
// - Reset, and its release, load the program counter with page 0 address 0.
// - Reset clears both interrupt control registers to 0000.
// - Reset clears converter, ext-interrupt, third timer and pull-up controls.
// - Reset clears ext0 request, both timer request flags and carry.
// - Back-up is entered only by entry instruction right after arm instruction.
// - An entry instruction not right after arm acts as no-operation.
// - Back-up stops oscillation but keeps RAM and reset circuit alive.
// - A power-down flag, tested by skip instruction, tells warm from cold.
// - Wakeup in back-up resumes at page 0 address 0, power flag 1.
// - Pin reset or watchdog reset starts at address 0, power flag 0.
// - Back-up retains RAM, oscillator, listed timer, converter, pull-up, wakeup regs; the code clears clock control clkc at entry.
// - Back-up entry initialises PC, accumulators, carry, listed regs, flags, watchdog.
// - Back-up entry sets the stack pointer to 7.
// - Timer 2 and its request flag are undefined after back-up.
// - Back-up sets port C latch to 1; D2 and other latches kept.
// - Back-up is left only by an external wakeup signal; the code also leaves it, as a cold start, on a reset pin low.
// - INT wakeup level chosen by ext-int control bit 2; no ext0 request.
// - Key-on low-level wakeup is enabled per port pin by wakeup registers.
package rrbs_pkg;

  localparam int ADDR_W = 5;

  // Register offsets
  localparam logic [4:0] A_ICTL1 = 5'h00;
  localparam logic [4:0] A_ICTL2 = 5'h01;
  localparam logic [4:0] A_EICTL = 5'h02;
  localparam logic [4:0] A_TCTL1 = 5'h03;
  localparam logic [4:0] A_TCTL2 = 5'h04;
  localparam logic [4:0] A_TCTL3 = 5'h05;
  localparam logic [4:0] A_CLKC  = 5'h06;
  localparam logic [4:0] A_CONV  = 5'h07;
  localparam logic [4:0] A_PU0   = 5'h08;
  localparam logic [4:0] A_PU1   = 5'h09;
  localparam logic [4:0] A_PU2   = 5'h0a;
  localparam logic [4:0] A_WK0   = 5'h0b;
  localparam logic [4:0] A_WK1   = 5'h0c;
  localparam logic [4:0] A_WK2   = 5'h0d;
  localparam logic [4:0] A_LATD  = 5'h10;
  localparam logic [4:0] A_LATP0 = 5'h11;
  localparam logic [4:0] A_LATP1 = 5'h12;
  localparam logic [4:0] A_LATP2 = 5'h13;
  localparam logic [4:0] A_LATC  = 5'h14;
  localparam logic [4:0] A_FLAGS = 5'h15;
  localparam logic [4:0] A_STAT  = 5'h16;
  localparam logic [4:0] A_SP    = 5'h17;

  // Field positions
  localparam int F_EXT0  = 0;
  localparam int F_T1    = 1;
  localparam int F_T2    = 2;
  localparam int F_CY    = 3;
  localparam int S_PWR   = 0;
  localparam int S_INTERRUPT_ENABLE_FLAG  = 1;
  localparam int S_WATCHDOG_FLAG_ONE  = 2;
  localparam int S_WEF   = 3;
  localparam int EI_LVL  = 2;
  localparam int WK1_SEL = 3;

  // Reset values
  localparam logic [3:0] RST_CTL   = 4'h0;
  localparam logic [3:0] RST_LAT4  = 4'hf;
  localparam logic [1:0] RST_LAT2  = 2'h3;
  localparam logic [2:0] RST_SP    = 3'h7;
  localparam logic [2:0] BKUP_SP   = 3'h7;
  localparam logic       RST_WEF   = 1'b1;
  localparam logic [6:0] PC_PAGE0  = 7'h00;
  localparam logic [6:0] PC_ADDR0  = 7'h00;
  localparam logic [15:0] WDT_ZERO = 16'h0000;
  localparam logic [15:0] WDT_LAST = 16'hffff;

  typedef enum logic [1:0] {
    ST_RUN    = 2'b01,
    ST_BACKUP = 2'b10
  } rrbs_state_t;

  typedef struct packed {
    rrbs_state_t state;
    logic        armed;
    logic        pwr;
    logic        skip;
    logic        pc_load;
    logic        core_rst;
    logic        bkup_init;
    logic [3:0]  ictl1;
    logic [3:0]  ictl2;
    logic [3:0]  eictl;
    logic [3:0]  tctl1;
    logic [3:0]  tctl2;
    logic [3:0]  tctl3;
    logic [3:0]  clkc;
    logic [3:0]  conv;
    logic [3:0]  pu0;
    logic [3:0]  pu1;
    logic [3:0]  pu2;
    logic [3:0]  wk0;
    logic [3:0]  wk1;
    logic [3:0]  wk2;
    logic [3:0]  latd;
    logic [3:0]  latp0;
    logic [3:0]  latp1;
    logic [1:0]  latp2;
    logic        latc;
    logic        ext0f;
    logic        t1f;
    logic        t2f;
    logic        adf;
    logic        cy;
    logic        interrupt_enable_flag;
    logic        watchdog_flag_one;
    logic        watchdog_enable_flag;
    logic [2:0]  sp;
    logic [15:0] wdt;
    logic [3:0]  rdata;
  } rrbs_st_t;

endpackage

// ---- design/rrbs_sequencer.sv ----
// Reset and RAM back-up sequencer of a 4-bit microcontroller core
`timescale 1ns/1ps
module rrbs_sequencer #(
  parameter logic [15:0] WDT_LAST = rrbs_pkg::WDT_LAST
) (
  // Clock, reset, enable
  input  wire logic                      mclk_i,
  input  wire logic                      nrst_i,
  input  wire logic                      cen_i,
  // External reset pin, active low, synchronous
  input  wire logic                      rst_pin_n_i,
  // Executed instruction decode
  input  wire logic                      instr_exec_i,
  input  wire logic                      power_off_arm_instr_i,
  input  wire logic                      backup_entry_instr_i,
  input  wire logic                      skip_if_power_flag_instr_i,
  input  wire logic                      watchdog_restart_instr_i,
  // Hardware flag set events
  input  wire logic                      ext0_evt_i,
  input  wire logic                      t1_evt_i,
  input  wire logic                      t2_evt_i,
  input  wire logic                      conv_done_evt_i,
  input  wire logic                      carry_set_i,
  // Register port
  input  wire logic [rrbs_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [3:0]                wdata_i,
  input  wire logic                      we_i,
  input  wire logic                      re_i,
  output logic      [3:0]                rdata_o,
  // Port pin levels
  input  wire logic [3:0]                p0_i,
  input  wire logic [3:0]                p1_i,
  input  wire logic [1:0]                p2_i,
  input  wire logic [3:0]                d_i,
  // Port pin drive, open drain
  output logic      [3:0]                p0_o,
  output logic      [3:0]                p0_oe_o,
  output logic      [3:0]                p1_o,
  output logic      [3:0]                p1_oe_o,
  output logic      [1:0]                p2_o,
  output logic      [1:0]                p2_oe_o,
  output logic      [3:0]                d_o,
  output logic      [3:0]                d_oe_o,
  // Pull-up enables
  output logic      [3:0]                pu_p0_o,
  output logic      [3:0]                pu_p1_o,
  output logic      [3:0]                pu_p2_o,
  // Core control
  output logic                           osc_run_o,
  output logic                           backup_o,
  output logic                           pc_load_o,
  output logic      [6:0]                pc_page_o,
  output logic      [6:0]                pc_addr_o,
  output logic                           core_rst_o,
  output logic                           bkup_init_o,
  output logic                           skip_o,
  output logic                           power_flag_o,
  output logic      [2:0]                stack_pointer_o,
  output logic                           interrupt_enable_flag_o
);

  rrbs_pkg::rrbs_st_t st_ff;
  rrbs_pkg::rrbs_st_t nxt_st;
  rrbs_pkg::rrbs_st_t rst_val;

  logic       in_run;
  logic       wdt_wrap;
  logic       wdt_rst;
  logic       cold;
  logic       wake;
  logic       key0;
  logic       key1;
  logic       key2;
  logic       int_wake;
  logic       wr;
  logic [3:0] rd_mux;

  // Cold reset image, shared by nrst_i, the reset pin and the watchdog
  always_comb begin
    rst_val           = '0;
    rst_val.state     = rrbs_pkg::ST_RUN;
    rst_val.pc_load   = 1'b1;
    rst_val.core_rst  = 1'b1;
    rst_val.pwr       = 1'b0;
    rst_val.ictl1     = rrbs_pkg::RST_CTL;
    rst_val.ictl2     = rrbs_pkg::RST_CTL;
    rst_val.eictl     = rrbs_pkg::RST_CTL;
    rst_val.tctl1     = rrbs_pkg::RST_CTL;
    rst_val.tctl2     = rrbs_pkg::RST_CTL;
    rst_val.tctl3     = rrbs_pkg::RST_CTL;
    rst_val.clkc      = rrbs_pkg::RST_CTL;
    rst_val.conv      = rrbs_pkg::RST_CTL;
    rst_val.pu0       = rrbs_pkg::RST_CTL;
    rst_val.pu1       = rrbs_pkg::RST_CTL;
    rst_val.pu2       = rrbs_pkg::RST_CTL;
    rst_val.wk0       = rrbs_pkg::RST_CTL;
    rst_val.wk1       = rrbs_pkg::RST_CTL;
    rst_val.wk2       = rrbs_pkg::RST_CTL;
    rst_val.latd      = rrbs_pkg::RST_LAT4;
    rst_val.latp0     = rrbs_pkg::RST_LAT4;
    rst_val.latp1     = rrbs_pkg::RST_LAT4;
    rst_val.latp2     = rrbs_pkg::RST_LAT2;
    rst_val.latc      = 1'b1;
    rst_val.ext0f     = 1'b0;
    rst_val.t1f       = 1'b0;
    rst_val.t2f       = 1'b0;
    rst_val.cy        = 1'b0;
    rst_val.watchdog_enable_flag       = rrbs_pkg::RST_WEF;
    rst_val.sp        = rrbs_pkg::RST_SP;
    rst_val.wdt       = rrbs_pkg::WDT_ZERO;
  end

  assign in_run   = (st_ff.state == rrbs_pkg::ST_RUN);
  assign wdt_wrap = in_run && st_ff.watchdog_enable_flag && (st_ff.wdt == WDT_LAST);
  // Second overflow with flag one still set resets the chip
  assign wdt_rst  = wdt_wrap && st_ff.watchdog_flag_one;
  // Reset circuit stays live in back-up, so the pin acts in any state
  assign cold     = !rst_pin_n_i || wdt_rst;

  // Wakeup sources, low-level key-on per enabled pin
  assign key0 = |(st_ff.wk0 & ~p0_i);
  assign key1 = |(st_ff.wk1[2:0] & ~p1_i[2:0]) |
                (st_ff.wk1[rrbs_pkg::WK1_SEL] & ~p1_i[3]);
  assign key2 = |(st_ff.wk2 & ~{d_i[3], d_i[2], p2_i});
  // Shared pin: INT wakeup only while key-on of bit 3 is off
  assign int_wake = !st_ff.wk1[rrbs_pkg::WK1_SEL] &&
                    (p1_i[3] == st_ff.eictl[rrbs_pkg::EI_LVL]);
  assign wake = !in_run && (key0 || key1 || key2 || int_wake);

  // Core is stopped in back-up, so software writes are dropped there
  assign wr = we_i && in_run;

  always_comb begin
    rd_mux = 4'h0;
    case (addr_i)
      rrbs_pkg::A_ICTL1: rd_mux = st_ff.ictl1;
      rrbs_pkg::A_ICTL2: rd_mux = st_ff.ictl2;
      rrbs_pkg::A_EICTL: rd_mux = st_ff.eictl;
      rrbs_pkg::A_TCTL1: rd_mux = st_ff.tctl1;
      rrbs_pkg::A_TCTL2: rd_mux = st_ff.tctl2;
      rrbs_pkg::A_TCTL3: rd_mux = st_ff.tctl3;
      rrbs_pkg::A_CLKC:  rd_mux = st_ff.clkc;
      rrbs_pkg::A_CONV:  rd_mux = st_ff.conv;
      rrbs_pkg::A_PU0:   rd_mux = st_ff.pu0;
      rrbs_pkg::A_PU1:   rd_mux = st_ff.pu1;
      rrbs_pkg::A_PU2:   rd_mux = st_ff.pu2;
      rrbs_pkg::A_WK0:   rd_mux = st_ff.wk0;
      rrbs_pkg::A_WK1:   rd_mux = st_ff.wk1;
      rrbs_pkg::A_WK2:   rd_mux = st_ff.wk2;
      rrbs_pkg::A_LATD:  rd_mux = st_ff.latd;
      rrbs_pkg::A_LATP0: rd_mux = st_ff.latp0;
      rrbs_pkg::A_LATP1: rd_mux = st_ff.latp1;
      rrbs_pkg::A_LATP2: rd_mux = {2'h0, st_ff.latp2};
      rrbs_pkg::A_LATC:  rd_mux = {3'h0, st_ff.latc};
      rrbs_pkg::A_FLAGS: rd_mux = {st_ff.cy, st_ff.t2f, st_ff.t1f,
                                   st_ff.ext0f};
      rrbs_pkg::A_STAT:  rd_mux = {st_ff.watchdog_enable_flag, st_ff.watchdog_flag_one, st_ff.interrupt_enable_flag,
                                   st_ff.pwr};
      rrbs_pkg::A_SP:    rd_mux = {1'b0, st_ff.sp};
      default:           rd_mux = 4'h0;
    endcase
  end

  always_comb begin
    nxt_st           = st_ff;
    nxt_st.pc_load   = 1'b0;
    nxt_st.core_rst  = 1'b0;
    nxt_st.bkup_init = 1'b0;
    nxt_st.skip      = 1'b0;
    nxt_st.rdata     = re_i ? rd_mux : 4'h0;

    // Software writes
    if (wr) begin
      case (addr_i)
        rrbs_pkg::A_ICTL1: nxt_st.ictl1 = wdata_i;
        rrbs_pkg::A_ICTL2: nxt_st.ictl2 = wdata_i;
        rrbs_pkg::A_EICTL: nxt_st.eictl = wdata_i;
        rrbs_pkg::A_TCTL1: nxt_st.tctl1 = wdata_i;
        rrbs_pkg::A_TCTL2: nxt_st.tctl2 = wdata_i;
        rrbs_pkg::A_TCTL3: nxt_st.tctl3 = wdata_i;
        rrbs_pkg::A_CLKC:  nxt_st.clkc  = wdata_i;
        rrbs_pkg::A_CONV:  nxt_st.conv  = wdata_i;
        rrbs_pkg::A_PU0:   nxt_st.pu0   = wdata_i;
        rrbs_pkg::A_PU1:   nxt_st.pu1   = wdata_i;
        rrbs_pkg::A_PU2:   nxt_st.pu2   = wdata_i;
        rrbs_pkg::A_WK0:   nxt_st.wk0   = wdata_i;
        rrbs_pkg::A_WK1:   nxt_st.wk1   = wdata_i;
        rrbs_pkg::A_WK2:   nxt_st.wk2   = wdata_i;
        rrbs_pkg::A_LATD:  nxt_st.latd  = wdata_i;
        rrbs_pkg::A_LATP0: nxt_st.latp0 = wdata_i;
        rrbs_pkg::A_LATP1: nxt_st.latp1 = wdata_i;
        rrbs_pkg::A_LATP2: nxt_st.latp2 = wdata_i[1:0];
        rrbs_pkg::A_LATC:  nxt_st.latc  = wdata_i[0];
        rrbs_pkg::A_FLAGS: begin
          nxt_st.ext0f = wdata_i[rrbs_pkg::F_EXT0];
          nxt_st.t1f   = wdata_i[rrbs_pkg::F_T1];
          nxt_st.t2f   = wdata_i[rrbs_pkg::F_T2];
          nxt_st.cy    = wdata_i[rrbs_pkg::F_CY];
        end
        rrbs_pkg::A_STAT: begin
          nxt_st.interrupt_enable_flag  = wdata_i[rrbs_pkg::S_INTERRUPT_ENABLE_FLAG];
          nxt_st.watchdog_enable_flag   = wdata_i[rrbs_pkg::S_WEF];
        end
        rrbs_pkg::A_SP:    nxt_st.sp    = wdata_i[2:0];
        default: begin
        end
      endcase
    end

    // Hardware sets win over a software clear in the same cycle
    if (in_run) begin
      nxt_st.ext0f = nxt_st.ext0f | ext0_evt_i;
      nxt_st.t1f   = nxt_st.t1f | t1_evt_i;
      nxt_st.t2f   = nxt_st.t2f | t2_evt_i;
      nxt_st.adf   = nxt_st.adf | conv_done_evt_i;
      nxt_st.cy    = nxt_st.cy | carry_set_i;
    end

    // Watchdog: first wrap sets flag one, restart clears it
    if (in_run && st_ff.watchdog_enable_flag) begin
      nxt_st.wdt = st_ff.wdt + 16'h0001;
    end
    if (wdt_wrap) begin
      nxt_st.wdt  = rrbs_pkg::WDT_ZERO;
      nxt_st.watchdog_flag_one = 1'b1;
    end else if (in_run && instr_exec_i && watchdog_restart_instr_i) begin
      nxt_st.watchdog_flag_one = 1'b0;
    end

    case (st_ff.state)
      rrbs_pkg::ST_RUN: begin
        if (instr_exec_i) begin
          // Arm holds for exactly the next executed instruction
          nxt_st.armed = power_off_arm_instr_i;
          if (skip_if_power_flag_instr_i) begin
            nxt_st.skip = st_ff.pwr;
          end
          // Without arm the entry instruction falls through as a no-op
          if (backup_entry_instr_i && st_ff.armed) begin
            nxt_st.state     = rrbs_pkg::ST_BACKUP;
            nxt_st.armed     = 1'b0;
            nxt_st.bkup_init = 1'b1;
            nxt_st.cy        = 1'b0;
            nxt_st.tctl1     = rrbs_pkg::RST_CTL;
            nxt_st.clkc      = rrbs_pkg::RST_CTL;
            nxt_st.ictl1     = rrbs_pkg::RST_CTL;
            nxt_st.ictl2     = rrbs_pkg::RST_CTL;
            nxt_st.ext0f     = 1'b0;
            nxt_st.t1f       = 1'b0;
            nxt_st.adf       = 1'b0;
            nxt_st.interrupt_enable_flag      = 1'b0;
            nxt_st.watchdog_enable_flag       = rrbs_pkg::RST_WEF;
            nxt_st.watchdog_flag_one      = 1'b0;
            nxt_st.wdt       = rrbs_pkg::WDT_ZERO;
            nxt_st.sp        = rrbs_pkg::BKUP_SP;
            nxt_st.latc      = 1'b1;
            // Timer 2 flag left as is; software treats it as undefined
            nxt_st.t2f       = st_ff.t2f;
          end
        end
      end
      rrbs_pkg::ST_BACKUP: begin
        // Retained controls are simply not touched here
        if (wake) begin
          nxt_st.state   = rrbs_pkg::ST_RUN;
          nxt_st.pwr     = 1'b1;
          nxt_st.pc_load = 1'b1;
        end
      end
      default: begin
        nxt_st.state = rrbs_pkg::ST_RUN;
      end
    endcase

    if (cold) begin
      nxt_st       = rst_val;
      nxt_st.rdata = re_i ? rd_mux : 4'h0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      st_ff <= rst_val;
    end else if (cen_i) begin
      st_ff <= nxt_st;
    end
  end

  // Open drain pins: a latch of 1 leaves the pin floating
  assign p0_o    = st_ff.latp0;
  assign p0_oe_o = ~st_ff.latp0;
  assign p1_o    = st_ff.latp1;
  assign p1_oe_o = ~st_ff.latp1;
  assign p2_o    = st_ff.latp2;
  assign p2_oe_o = ~st_ff.latp2;
  // D2 and C share one pin, either latch at 0 pulls it low
  assign d_o     = {st_ff.latd[3], st_ff.latd[2] & st_ff.latc,
                    st_ff.latd[1:0]};
  assign d_oe_o  = ~d_o;

  assign pu_p0_o = st_ff.pu0;
  assign pu_p1_o = st_ff.pu1;
  assign pu_p2_o = st_ff.pu2;

  assign osc_run_o               = in_run;
  assign backup_o                = !in_run;
  assign pc_load_o               = st_ff.pc_load;
  assign pc_page_o               = rrbs_pkg::PC_PAGE0;
  assign pc_addr_o               = rrbs_pkg::PC_ADDR0;
  assign core_rst_o              = st_ff.core_rst;
  assign bkup_init_o             = st_ff.bkup_init;
  assign skip_o                  = st_ff.skip;
  assign power_flag_o            = st_ff.pwr;
  assign stack_pointer_o         = st_ff.sp;
  assign interrupt_enable_flag_o = st_ff.interrupt_enable_flag;
  assign rdata_o                 = st_ff.rdata;

endmodule

// ---- testbench/rrbs_checker.sv ----
// Port assertions for the reset and back-up sequencer
`timescale 1ns/1ps
module rrbs_checker (
  // Clock, resets, decode
  input wire logic       mclk_i,
  input wire logic       nrst_i,
  input wire logic       cen_i,
  input wire logic       rst_pin_n_i,
  input wire logic       instr_exec_i,
  input wire logic       power_off_arm_instr_i,
  input wire logic       backup_entry_instr_i,
  input wire logic       skip_if_power_flag_instr_i,
  // Watched outputs
  input wire logic [3:0] p0_oe_o,
  input wire logic [3:0] pu_p0_o,
  input wire logic       osc_run_o,
  input wire logic       pc_load_o,
  input wire logic [6:0] pc_page_o,
  input wire logic [6:0] pc_addr_o,
  input wire logic       core_rst_o,
  input wire logic       bkup_init_o,
  input wire logic       skip_o,
  input wire logic       power_flag_o,
  input wire logic [2:0] stack_pointer_o
);
  logic armed_ff;
  logic go_entry;
  // Any executed instruction other than arm drops the arming
  always_ff @(posedge mclk_i) begin
    if (!nrst_i || !rst_pin_n_i)
      armed_ff <= 1'b0;
    else if (cen_i && instr_exec_i)
      armed_ff <= power_off_arm_instr_i;
  end
  assign go_entry = cen_i && instr_exec_i && backup_entry_instr_i &&
                    osc_run_o && rst_pin_n_i;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!nrst_i);
  property p_rst_img;
    $rose(nrst_i) |-> pu_p0_o == 4'h0 && p0_oe_o == 4'h0;
  endproperty
  a_rst_img: assert property (p_rst_img)
    else $error("reset pin image wrong");
  property p_rst_pc;
    $rose(nrst_i) |-> ##[0:1] (pc_load_o && core_rst_o && !power_flag_o);
  endproperty
  a_rst_pc: assert property (p_rst_pc)
    else $error("no cold start after reset");
  property p_pin_rst;
    cen_i && !rst_pin_n_i |=> pc_load_o && !power_flag_o && osc_run_o;
  endproperty
  a_pin_rst: assert property (p_pin_rst)
    else $error("reset pin did not cold start");
  property p_pc_zero;
    pc_load_o |-> pc_page_o == 7'h00 && pc_addr_o == 7'h00;
  endproperty
  a_pc_zero: assert property (p_pc_zero)
    else $error("start address not zero");
  property p_wake;
    $rose(osc_run_o) && $past(rst_pin_n_i) |-> power_flag_o && pc_load_o;
  endproperty
  a_wake: assert property (p_wake)
    else $error("warm start without power flag");
  property p_entry;
    go_entry && armed_ff |=>
      !osc_run_o && bkup_init_o && stack_pointer_o == 3'h7;
  endproperty
  a_entry: assert property (p_entry)
    else $error("armed entry did not reach back-up");
  property p_nop;
    go_entry && !armed_ff |=> osc_run_o && !bkup_init_o;
  endproperty
  a_nop: assert property (p_nop)
    else $error("unarmed entry acted");
  property p_skip;
    cen_i && instr_exec_i && skip_if_power_flag_instr_i && osc_run_o
      |=> skip_o == power_flag_o;
  endproperty
  a_skip: assert property (p_skip)
    else $error("skip does not follow power flag");
endmodule

bind rrbs_sequencer rrbs_checker i_chk (
  .mclk_i, .nrst_i, .cen_i, .rst_pin_n_i, .instr_exec_i,
  .power_off_arm_instr_i, .backup_entry_instr_i,
  .skip_if_power_flag_instr_i, .p0_oe_o, .pu_p0_o, .osc_run_o,
  .pc_load_o, .pc_page_o, .pc_addr_o, .core_rst_o, .bkup_init_o,
  .skip_o, .power_flag_o, .stack_pointer_o
);

// ---- testbench/rrbs_partner.sv ----
// Far side: reset pin circuit and key inputs with pull-ups
`timescale 1ns/1ps
module rrbs_partner (
  // Clock and bench requests
  input  wire logic       mclk_i,
  input  wire logic       wake_i,
  input  wire logic       prst_i,
  // Pins pulled low by the sequencer
  input  wire logic [3:0] p0_dn_i,
  input  wire logic [3:0] p1_dn_i,
  input  wire logic [1:0] p2_dn_i,
  input  wire logic [3:0] d_dn_i,
  // Resolved levels
  output logic      [3:0] p0_o,
  output logic      [3:0] p1_o,
  output logic      [1:0] p2_o,
  output logic      [3:0] d_o,
  output logic            rst_pin_n_o
);
  logic [2:0] key_ff = 3'h0;
  logic [2:0] rst_ff = 3'h0;
  always @(posedge mclk_i) begin
    key_ff <= wake_i ? 3'h4 : key_ff - {2'h0, key_ff != 3'h0};
    rst_ff <= prst_i ? 3'h2 : rst_ff - {2'h0, rst_ff != 3'h0};
  end
  // Key P00 pressed low; released lines float back high
  assign p0_o = {3'h7, key_ff == 3'h0} & ~p0_dn_i;
  assign p1_o = ~p1_dn_i;
  assign p2_o = ~p2_dn_i;
  assign d_o = ~d_dn_i;
  assign rst_pin_n_o = (rst_ff == 3'h0);
endmodule

// ---- testbench/tb_top.sv ----
// Self-checking bench for the reset and back-up sequencer
`timescale 1ns/1ps
module tb_top;
  logic        mclk_i, nrst_i, cen_i, rst_pin_n_i, instr_exec_i, we_i, re_i;
  logic        power_off_arm_instr_i, backup_entry_instr_i;
  logic        skip_if_power_flag_instr_i, watchdog_restart_instr_i;
  logic        ext0_evt_i, t1_evt_i, t2_evt_i, conv_done_evt_i, carry_set_i;
  logic [4:0]  addr_i;
  logic [3:0]  wdata_i, rdata_o, p0_i, p1_i, d_i, p0_o, p0_oe_o, p1_o;
  logic [3:0]  p1_oe_o, d_o, d_oe_o, pu_p0_o, pu_p1_o, pu_p2_o, ld;
  logic [1:0]  p2_i, p2_o, p2_oe_o;
  logic        osc_run_o, backup_o, pc_load_o, core_rst_o, bkup_init_o;
  logic        skip_o, power_flag_o, interrupt_enable_flag_o;
  logic [6:0]  pc_page_o, pc_addr_o;
  logic [2:0]  stack_pointer_o;
  logic        wake_r, prst_r;
  // Owned by the read monitor alone
  logic        rd_seen = 1'b0;
  logic [3:0]  exp_q[$];
  logic [3:0]  rv[14];
  logic [13:0] keep = 14'h3fb4;
  int          errors, checked, seed, r;

  rrbs_sequencer #(.WDT_LAST(16'h000f)) i_dut (
    .mclk_i, .nrst_i, .cen_i, .rst_pin_n_i, .instr_exec_i,
    .power_off_arm_instr_i, .backup_entry_instr_i,
    .skip_if_power_flag_instr_i, .watchdog_restart_instr_i,
    .ext0_evt_i, .t1_evt_i, .t2_evt_i, .conv_done_evt_i, .carry_set_i,
    .addr_i, .wdata_i, .we_i, .re_i, .rdata_o, .p0_i, .p1_i, .p2_i, .d_i,
    .p0_o, .p0_oe_o, .p1_o, .p1_oe_o, .p2_o, .p2_oe_o, .d_o, .d_oe_o,
    .pu_p0_o, .pu_p1_o, .pu_p2_o, .osc_run_o, .backup_o, .pc_load_o,
    .pc_page_o, .pc_addr_o, .core_rst_o, .bkup_init_o, .skip_o,
    .power_flag_o, .stack_pointer_o, .interrupt_enable_flag_o
  );
  rrbs_partner i_far (
    .mclk_i, .wake_i(wake_r), .prst_i(prst_r),
    .p0_dn_i(p0_oe_o & ~p0_o), .p1_dn_i(p1_oe_o & ~p1_o),
    .p2_dn_i(p2_oe_o & ~p2_o), .d_dn_i(d_oe_o & ~d_o),
    .p0_o(p0_i), .p1_o(p1_i), .p2_o(p2_i), .d_o(d_i),
    .rst_pin_n_o(rst_pin_n_i)
  );

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [3:0] d);
    @(posedge mclk_i);
    {addr_i, wdata_i, we_i} <= {a, d, 1'b1};
    @(posedge mclk_i);
    we_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [4:0] a, input logic [3:0] e);
    @(posedge mclk_i);
    {addr_i, re_i} <= {a, 1'b1};
    exp_q.push_back(e);
    @(posedge mclk_i);
    re_i <= 1'b0;
  endtask
  // Kind 0 arm, 1 entry, 2 skip, 3 restart, other plain
  task automatic ex(input int k);
    @(posedge mclk_i);
    instr_exec_i <= 1'b1;
    power_off_arm_instr_i <= (k == 0);
    backup_entry_instr_i <= (k == 1);
    skip_if_power_flag_instr_i <= (k == 2);
    watchdog_restart_instr_i <= (k == 3);
    @(posedge mclk_i);
    instr_exec_i <= 1'b0;
    #1;
  endtask
  task automatic give_verdict();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge mclk_i) begin
    if (rd_seen)
      chk(rdata_o, exp_q.pop_front());
    rd_seen <= re_i;
  end
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end
  initial begin
    #20000;
    errors++;
    give_verdict();
  end

  initial begin
    {nrst_i, instr_exec_i, we_i, re_i, wake_r, prst_r} = '0;
    {power_off_arm_instr_i, backup_entry_instr_i, addr_i, wdata_i} = '0;
    {skip_if_power_flag_instr_i, watchdog_restart_instr_i} = '0;
    {ext0_evt_i, t1_evt_i, t2_evt_i, conv_done_evt_i, carry_set_i} = '0;
    {cen_i, errors, checked, seed} = {1'b1, 32'd0, 32'd0, 32'd19732};
    repeat (5) @(posedge mclk_i);
    nrst_i <= 1'b1;
    rd(rrbs_pkg::A_STAT, 4'h8);
    // Watchdog off early, short wrap would cold start us
    wr(rrbs_pkg::A_STAT, 4'h0);
    chk({pu_p0_o, pu_p1_o, pu_p2_o}, 16'h0);
    chk({p0_oe_o, p1_oe_o, p2_oe_o, d_oe_o}, 16'h0);
    for (int a = 0; a < 14; a++) rd(5'(a), 4'h0);
    rd(rrbs_pkg::A_FLAGS, 4'h0);
    rd(rrbs_pkg::A_SP, 4'h7);
    rd(rrbs_pkg::A_LATP0, 4'hf);
    rd(rrbs_pkg::A_LATP2, 4'h3);
    rd(rrbs_pkg::A_LATC, 4'h1);
    rd(5'h1f, 4'h0);
    // Only the P00 key and P13 key may wake; pins idle high
    for (int a = 0; a < 14; a++) begin
      r = $random(seed);
      rv[a] = (a == 11) ? 4'h1 : (a == 12) ? 4'h8 : (a == 13) ? 4'h0 : r[3:0];
      wr(5'(a), rv[a]);
    end
    r = $random(seed);
    ld = r[3:0];
    wr(rrbs_pkg::A_LATD, ld);
    wr(rrbs_pkg::A_LATC, 4'h0);
    wr(rrbs_pkg::A_STAT, 4'h2);
    chk(interrupt_enable_flag_o, 1'b1);
    {ext0_evt_i, t1_evt_i, t2_evt_i, conv_done_evt_i, carry_set_i} <= 5'h1f;
    @(posedge mclk_i);
    {ext0_evt_i, t1_evt_i, t2_evt_i, conv_done_evt_i, carry_set_i} <= 5'h00;
    rd(rrbs_pkg::A_FLAGS, 4'hf);
    ex(3);
    ex(1);
    chk(osc_run_o, 1'b1);
    ex(0);
    ex(4);
    ex(1);
    chk(osc_run_o, 1'b1);
    ex(0);
    ex(1);
    chk({osc_run_o, backup_o}, 2'b01);
    repeat (6) @(posedge mclk_i);
    chk(osc_run_o, 1'b0);
    wake_r <= 1'b1;
    @(posedge mclk_i);
    wake_r <= 1'b0;
    for (int i = 0; i < 20 && osc_run_o !== 1'b1; i++) @(posedge mclk_i);
    chk(power_flag_o, 1'b1);
    rd(rrbs_pkg::A_STAT, 4'h9);
    wr(rrbs_pkg::A_STAT, 4'h0);
    for (int a = 0; a < 14; a++)
      rd(5'(a), keep[a] ? rv[a] : 4'h0);
    // Timer 2 flag is simply kept across back-up
    rd(rrbs_pkg::A_FLAGS, 4'h4);
    rd(rrbs_pkg::A_SP, 4'h7);
    rd(rrbs_pkg::A_LATC, 4'h1);
    rd(rrbs_pkg::A_LATD, ld);
    chk(pu_p0_o, rv[8]);
    ex(2);
    chk(skip_o, 1'b1);
    wr(rrbs_pkg::A_STAT, 4'h8);
    for (int i = 0; i < 60 && core_rst_o !== 1'b1; i++) @(posedge mclk_i);
    chk(power_flag_o, 1'b0);
    ex(3);
    ex(0);
    ex(1);
    prst_r <= 1'b1;
    repeat (2) @(posedge mclk_i);
    prst_r <= 1'b0;
    repeat (4) @(posedge mclk_i);
    chk({osc_run_o, power_flag_o}, 2'b10);
    give_verdict();
  end
endmodule
